/* gepc_regs.svh */
/*
 * register offsets, field positions, reset values and codes for the gated event/period counter.
 * assumes a plain byte-addressed register port with one-cycle read latency.
 */
`ifndef GEPC_REGS_SVH
`define GEPC_REGS_SVH

// ==========================================
// register offsets (byte addresses, 32-bit words)
`define GEPC_CTRL_OFS 8'h00
`define GEPC_STATUS_OFS 8'h04
`define GEPC_COUNT_LO_OFS 8'h08
`define GEPC_COUNT_HI_OFS 8'h0C
`define GEPC_HOLD_LO_OFS 8'h10
`define GEPC_HOLD_HI_OFS 8'h14

// ==========================================
// per-stage control field positions (one 16-bit half-word per stage)
`define GEPC_F_TB_LSB 0
`define GEPC_F_TB_MSB 3
`define GEPC_F_EDGE 4
`define GEPC_F_CONT 5
`define GEPC_F_OTYPE 6
`define GEPC_F_OPOL 7
`define GEPC_F_GATE_LSB 8
`define GEPC_F_GATE_MSB 10
`define GEPC_F_RUN 11
`define GEPC_F_PERIOD 12
`define GEPC_STAGE_STRIDE 16

// ==========================================
// timebase and gating codes
`define GEPC_TB_CHAIN 4'h0
`define GEPC_TB_EXT_LO 4'h6
`define GEPC_TB_EXT_HI 4'hA
`define GEPC_GATE_NONE 3'h0
`define GEPC_GATE_HIGH 3'h1
`define GEPC_GATE_LOW 3'h2
`define GEPC_GATE_RISE 3'h3
`define GEPC_GATE_FALL 3'h4

// ==========================================
// counts and reset values
`define GEPC_STAGE_MAX 16'hFFFF
`define GEPC_OVF_RESIDUE 16'h0001
`define GEPC_CTRL_RST 32'h0000_0000
`endif

/* gepc_pkg.sv */
/*
 * types shared by the gated event/period counter.
 * assumes nothing of its surroundings.
 */
package gepc_pkg;
    // ==========================================
    // measurement phase of a stage
    typedef enum logic [1:0] {
        GEPC_IDLE,
        GEPC_ARMED,
        GEPC_COUNTING,
        GEPC_STOPPED
    } gepc_phase_t;
endpackage

/* gepc_counter.sv */
/*
 * chain of 16-bit gated counter stages with event, period and pulse-width
 * measurement, per-stage hold registers and terminal-count outputs.
 * assumes source and gate inputs synchronous to sys_clk; register port as
 * a plain one-cycle strobe interface.
 */
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "gepc_regs.svh"

// Functional notes
// - count on selected rising or falling edge
// - timebase codes 6-10 select external source
// - level gating counts only while gate active
// - edge gating starts counting at gate edge
// - continuous mode rolls over without overflow flag
// - timebase zero clocks from lower stage output
// - 16-bit stages chain to 32 or 48 bits
// - lower stages pulse terminal count on rollover
// - non-continuous top stage stops on overflow
// - period mode latches hold on next edge
// - after period latch reload zero, continue
// - period overflow latches residue, awaits new trigger
// - pulse mode latches on gate inactive, reloads
// - pulse mode counts through overflow, latches later
// - hold register readable while measurement runs
// - one stage output gates another stage; here only when wired to that stage's ext_gate pin
// - terminal count at 65535 rollover
// - toggled output flips after terminal count
module gepc_counter #(
    parameter int STAGES = 3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // external signals, one per stage
    input wire logic [STAGES-1:0] ext_source,
    input wire logic [STAGES-1:0] ext_gate,
    output logic [STAGES-1:0] ctr_out
);
    // ==========================================
    // configuration
    logic [31:0] ctrl_lo_r; // stages 0 and 1
    logic [31:0] ctrl_hi_r; // stage 2
    logic [47:0] cfg_all;
    logic [15:0] cnt_r [STAGES];
    logic [15:0] hold_r [STAGES];
    logic [STAGES-1:0] ovf_r; // sticky overflow flags
    logic [STAGES-1:0] tc_out; // rollover pulse per stage
    logic [STAGES-1:0] src_q_r; // previous source level
    logic [STAGES-1:0] gate_q_r; // previous gate level
    logic [STAGES-1:0] out_tog_r; // toggled-output state
    logic [STAGES-1:0] tc_pend_r; // toggle waits for next tick
    gepc_pkg::gepc_phase_t phase_r [STAGES];

    assign cfg_all = {ctrl_hi_r[15:0], ctrl_lo_r};

    // control writes; a rewrite restarts the stage and clears its flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_lo_r <= `GEPC_CTRL_RST;
            ctrl_hi_r <= `GEPC_CTRL_RST;
        end else if (reg_wr && reg_addr == `GEPC_CTRL_OFS) begin
            ctrl_lo_r <= reg_wdata;
        end else if (reg_wr && reg_addr == `GEPC_STATUS_OFS) begin
            ctrl_hi_r <= {16'h0000, reg_wdata[15:0]};
        end
    end

    // ==========================================
    // per-stage counter logic
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : stg
            logic [15:0] cfg;
            logic [3:0] tb;
            logic [2:0] gmode;
            logic src_lvl;
            logic tick;
            logic gate_lvl;
            logic gate_act;
            logic gate_edge;
            logic cfg_wr;
            logic roll;
            logic count_en; // this tick really moves the count
            assign cfg = cfg_all[g*`GEPC_STAGE_STRIDE +: 16];
            assign tb = cfg[`GEPC_F_TB_MSB:`GEPC_F_TB_LSB];
            assign gmode = cfg[`GEPC_F_GATE_MSB:`GEPC_F_GATE_LSB];
            assign cfg_wr = reg_wr && ((g < 2) ? reg_addr == `GEPC_CTRL_OFS
                                                : reg_addr == `GEPC_STATUS_OFS);
            // source pick: lower stage output in chain, else external pin
            if (g == 0) begin : s0
                assign src_lvl = ext_source[g];
            end else begin : sn
                assign src_lvl = (tb == `GEPC_TB_CHAIN) ? ctr_out[g-1] : ext_source[g];
            end
            // edge picked by polarity bit; 1 = rising
            assign tick = cfg[`GEPC_F_EDGE] ? (src_lvl && !src_q_r[g])
                                           : (!src_lvl && src_q_r[g]);
            assign gate_lvl = ext_gate[g]; // may be wired to another stage's out
            assign gate_act = (gmode == `GEPC_GATE_LOW) ? !gate_lvl : gate_lvl;
            assign gate_edge = (gmode == `GEPC_GATE_FALL) ? (!gate_lvl && gate_q_r[g])
                                                         : (gate_lvl && !gate_q_r[g]);
            // a held stage must not fake a rollover: a gated or idle stage at
            // full scale would otherwise clock the next stage of a chain
            assign count_en = cfg[`GEPC_F_RUN] && (cfg[`GEPC_F_PERIOD]
                ? ((gmode >= `GEPC_GATE_RISE)
                    ? (phase_r[g] == gepc_pkg::GEPC_COUNTING && !gate_edge)
                    : gate_act)
                : (phase_r[g] == gepc_pkg::GEPC_COUNTING
                    && (gmode == `GEPC_GATE_NONE || gmode >= `GEPC_GATE_RISE || gate_act)));
            assign roll = tick && count_en && cnt_r[g] == `GEPC_STAGE_MAX;
            assign tc_out[g] = roll;

            // edge history of source and gate
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    src_q_r[g] <= 1'b0;
                    gate_q_r[g] <= 1'b0;
                end else begin
                    src_q_r[g] <= src_lvl;
                    gate_q_r[g] <= gate_lvl;
                end
            end

            // phase, count, hold and overflow
            always_ff @(posedge sys_clk) begin
                if (rst || cfg_wr) begin
                    phase_r[g] <= gepc_pkg::GEPC_IDLE;
                    cnt_r[g] <= 16'h0000;
                    hold_r[g] <= 16'h0000;
                    ovf_r[g] <= 1'b0;
                end else if (!cfg[`GEPC_F_RUN]) begin
                    phase_r[g] <= gepc_pkg::GEPC_IDLE;
                end else if (cfg[`GEPC_F_PERIOD] && gmode >= `GEPC_GATE_RISE) begin
                    // period measurement between like gate edges
                    case (phase_r[g])
                        gepc_pkg::GEPC_IDLE, gepc_pkg::GEPC_ARMED: begin
                            if (gate_edge) begin
                                phase_r[g] <= gepc_pkg::GEPC_COUNTING;
                                cnt_r[g] <= 16'h0000;
                            end
                        end
                        default: begin
                            if (gate_edge) begin
                                hold_r[g] <= cnt_r[g];
                                cnt_r[g] <= 16'h0000;
                            end else if (roll) begin
                                // too fast a timebase: keep a small residue, re-arm
                                hold_r[g] <= `GEPC_OVF_RESIDUE;
                                cnt_r[g] <= 16'h0000;
                                phase_r[g] <= gepc_pkg::GEPC_ARMED;
                            end else if (tick) begin
                                cnt_r[g] <= cnt_r[g] + 16'h0001;
                            end
                        end
                    endcase
                end else if (cfg[`GEPC_F_PERIOD]) begin
                    // continuous pulse width; counts through rollover
                    if (gate_act && tick) begin
                        cnt_r[g] <= cnt_r[g] + 16'h0001;
                    end else if (!gate_act && gate_q_r[g] != gate_lvl) begin
                        hold_r[g] <= cnt_r[g];
                        cnt_r[g] <= 16'h0000;
                    end
                    phase_r[g] <= gepc_pkg::GEPC_COUNTING;
                end else begin
                    // event counting, gated or not
                    case (phase_r[g])
                        gepc_pkg::GEPC_IDLE: begin
                            if (gmode == `GEPC_GATE_RISE || gmode == `GEPC_GATE_FALL) begin
                                phase_r[g] <= gepc_pkg::GEPC_ARMED;
                            end else begin
                                phase_r[g] <= gepc_pkg::GEPC_COUNTING;
                            end
                        end
                        gepc_pkg::GEPC_ARMED: begin
                            if (gate_edge) begin
                                phase_r[g] <= gepc_pkg::GEPC_COUNTING;
                            end
                        end
                        gepc_pkg::GEPC_COUNTING: begin
                            if (tick && (gmode == `GEPC_GATE_NONE || gmode >= `GEPC_GATE_RISE
                                         || gate_act)) begin
                                cnt_r[g] <= cnt_r[g] + 16'h0001;
                                if (roll && !cfg[`GEPC_F_CONT]) begin
                                    ovf_r[g] <= 1'b1;
                                    phase_r[g] <= gepc_pkg::GEPC_STOPPED;
                                end
                            end
                        end
                        default: begin
                            phase_r[g] <= gepc_pkg::GEPC_STOPPED;
                        end
                    endcase
                end
            end

            // output: pulse on rollover or toggle on the following tick
            always_ff @(posedge sys_clk) begin
                if (rst || cfg_wr) begin
                    out_tog_r[g] <= 1'b0;
                    tc_pend_r[g] <= 1'b0;
                    ctr_out[g] <= 1'b0;
                end else begin
                    if (roll) begin
                        tc_pend_r[g] <= 1'b1;
                    end else if (tick && tc_pend_r[g]) begin
                        tc_pend_r[g] <= 1'b0;
                        out_tog_r[g] <= !out_tog_r[g];
                    end
                    if (cfg[`GEPC_F_OTYPE]) begin
                        ctr_out[g] <= (out_tog_r[g] ^ (tick && tc_pend_r[g]))
                                      ^ !cfg[`GEPC_F_OPOL];
                    end else begin
                        ctr_out[g] <= tc_out[g] ^ !cfg[`GEPC_F_OPOL];
                    end
                end
            end

            // latch step shared by period and pulse-width measurement
            sequence latch_reload_s;
                hold_r[g] == $past(cnt_r[g]) && cnt_r[g] == 16'h0000;
            endsequence
            // in pulse output mode with positive polarity a rollover raises ctr_out in the next cycle
            rollover_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
                roll && !cfg[`GEPC_F_OTYPE] && cfg[`GEPC_F_OPOL] && !cfg_wr |=> ctr_out[g])
                else $error("tc pulse missing after rollover");
            period_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_RUN] && cfg[`GEPC_F_PERIOD] && gmode >= `GEPC_GATE_RISE && !cfg_wr
                && phase_r[g] == gepc_pkg::GEPC_COUNTING && gate_edge
                |=> latch_reload_s)
                else $error("period result not latched");
            overflow_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
                ovf_r[g] && !cfg_wr |=> ovf_r[g])
                else $error("overflow flag dropped");
            stop_on_ovf_a: assert property (@(posedge sys_clk) disable iff (rst)
                phase_r[g] == gepc_pkg::GEPC_STOPPED && !cfg_wr && !cfg[`GEPC_F_PERIOD]
                |=> $stable(cnt_r[g]))
                else $error("stopped stage kept counting");
            cont_no_ovf_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_CONT] && !ovf_r[g] && !cfg_wr |=> !ovf_r[g])
                else $error("continuous mode flagged overflow");
            period_residue_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_RUN] && cfg[`GEPC_F_PERIOD] && gmode >= `GEPC_GATE_RISE && !cfg_wr
                && phase_r[g] == gepc_pkg::GEPC_COUNTING && roll && !gate_edge
                |=> hold_r[g] == `GEPC_OVF_RESIDUE && phase_r[g] == gepc_pkg::GEPC_ARMED)
                else $error("period overflow not handled");
            level_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_RUN] && !cfg[`GEPC_F_PERIOD] && !cfg_wr && tick
                && (gmode == `GEPC_GATE_HIGH || gmode == `GEPC_GATE_LOW) && !gate_act
                |=> $stable(cnt_r[g]))
                else $error("counted with gate inactive");
            pulse_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_RUN] && cfg[`GEPC_F_PERIOD] && gmode != `GEPC_GATE_NONE
                && gmode < `GEPC_GATE_RISE && !cfg_wr && !gate_act && gate_q_r[g] != gate_lvl
                |=> latch_reload_s)
                else $error("pulse width not latched");
            armed_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_RUN] && !cfg[`GEPC_F_PERIOD] && !cfg_wr
                && phase_r[g] == gepc_pkg::GEPC_ARMED |=> $stable(cnt_r[g]))
                else $error("armed stage counted before gate edge");
            toggle_flip_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_OTYPE] && !cfg_wr && tick && tc_pend_r[g] && !roll
                |=> out_tog_r[g] != $past(out_tog_r[g]))
                else $error("toggled output missed its flip");
            edge_count_a: assert property (@(posedge sys_clk) disable iff (rst)
                cfg[`GEPC_F_RUN] && !cfg[`GEPC_F_PERIOD] && !cfg_wr && tick
                && phase_r[g] == gepc_pkg::GEPC_COUNTING && gmode == `GEPC_GATE_NONE
                |=> cnt_r[g] == $past(cnt_r[g]) + 16'h0001)
                else $error("selected edge not counted");
        end
    endgenerate

    // ==========================================
    // register reads; hold values are live while counting continues
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `GEPC_CTRL_OFS) begin
                reg_rdata <= ctrl_lo_r;
            end else if (reg_addr == `GEPC_STATUS_OFS) begin
                reg_rdata <= {13'h0000, ovf_r, ctrl_hi_r[15:0]};
            end else if (reg_addr == `GEPC_COUNT_LO_OFS) begin
                reg_rdata <= {cnt_r[1], cnt_r[0]};
            end else if (reg_addr == `GEPC_COUNT_HI_OFS) begin
                reg_rdata <= {16'h0000, cnt_r[2]};
            end else if (reg_addr == `GEPC_HOLD_LO_OFS) begin
                reg_rdata <= {hold_r[1], hold_r[0]};
            end else if (reg_addr == `GEPC_HOLD_HI_OFS) begin
                reg_rdata <= {16'h0000, hold_r[2]};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

/* gepc_far_side.sv */
/*
 * far-side model of the gated counter: source and gate levels of each stage.
 * assumes the bench calls its tasks and that sys_clk is shared with the counter.
 */
`timescale 1ns/1ps

// ==========================================
// source and gate driver
module gepc_far_side (
    // clock
    input wire logic sys_clk,
    // levels toward the counter
    output logic [2:0] source,
    output logic [2:0] gate
);
    // both lines are always driven, idle low
    initial begin
        source = 3'h0;
        gate = 3'h0;
    end

    // whole pulses; four cycles per level so each edge is sampled alone
    task automatic pulses(input int s, input int n);
        repeat (n) begin
            @(posedge sys_clk) source[s] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            source[s] <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask

    // move a gate, then let it settle before any source edge
    task automatic gate_to(input int s, input logic v);
        @(posedge sys_clk) gate[s] <= v;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

/* testbench.sv */
/*
 * self-checking bench of the gated counter: event, gated, time-lapse,
 * chained, period and pulse-width runs with random edge counts.
 * assumes gepc_counter with three stages and the far-side model.
 */
`timescale 1ns/1ps
`include "gepc_regs.svh"

module testbench;
    // ==========================================
    // signals
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0] ext_source;
    logic [2:0] ext_gate;
    logic [2:0] ctr_out;
    logic [31:0] seed = 32'h0000_0053; // xorshift state
    logic [31:0] cfg01 = 32'h0000_0000; // shadow of the shared stage 0/1 word
    int failures = 0;
    int num_checks = 0;

    always #4 sys_clk = ~sys_clk;

    gepc_counter #(.STAGES(3)) uut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_source(ext_source), .ext_gate(ext_gate), .ctr_out(ctr_out)
    );
    gepc_far_side far (.sys_clk(sys_clk), .source(ext_source), .gate(ext_gate));

    // ==========================================
    // expectation helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // small counts keep every run short
    function automatic int rnd();
        return int'(xs() % 32'h0000_000C) + 1;
    endfunction
    // run set, positive polarity; a stopping stage gets the toggled output
    function automatic logic [15:0] ctl(input logic [3:0] tb, input logic rise,
        input logic cont, input logic [2:0] g, input logic per);
        return {3'h0, per, 1'b1, g, 1'b1, ~cont, cont, rise, tb};
    endfunction
    function automatic logic [7:0] hold_ofs(input int s);
        return (s == 2) ? `GEPC_HOLD_HI_OFS : `GEPC_HOLD_LO_OFS;
    endfunction
    function automatic logic [7:0] cnt_ofs(input int s);
        return (s == 2) ? `GEPC_COUNT_HI_OFS : `GEPC_COUNT_LO_OFS;
    endfunction
    // stage 1 sits in the upper half of the shared word
    function automatic logic [31:0] place(input int s, input int v);
        return (s == 1) ? {16'(v), 16'h0000} : {16'h0000, 16'(v)};
    endfunction

    // ==========================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // writing either control word clears the stages behind it
    task automatic cfg(input int s, input logic [15:0] w);
        if (s == 2) begin
            wr(`GEPC_STATUS_OFS, {16'h0000, w});
        end else begin
            cfg01[s*16 +: 16] = w;
            wr(`GEPC_CTRL_OFS, cfg01);
        end
    endtask
    // one trigger edge away from the idle level and back
    task automatic gate_edge(input int s, input logic idle);
        far.gate_to(s, ~idle);
        far.gate_to(s, idle);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #200_000;
        failures++;
        wrap_up();
    end

    // ==========================================
    // main sequence
    initial begin
        int k;
        int n;
        int s;
        logic [15:0] w;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values, unmapped places read zero
        for (int a = 0; a < 8; a++) begin
            rdchk(8'(a * 4), 32'h0000_0000);
        end
        // a cleared control word means negative polarity: idle outputs high
        chk({29'h0, ctr_out}, 32'h0000_0007);
        // control readback; an unmapped write is dropped
        w = 16'(xs()) & 16'h07FF;
        wr(`GEPC_STATUS_OFS, {16'h0000, w});
        wr(8'h1C, 32'hFFFF_FFFF);
        rdchk(`GEPC_STATUS_OFS, {16'h0000, w});
        rdchk(8'h1C, 32'h0000_0000);
        // every external timebase code, both edge senses
        for (int t = 0; t < 5; t++) begin
            k = rnd();
            cfg(0, ctl(4'(6 + t), t[0], 1'b1, `GEPC_GATE_NONE, 1'b0));
            far.pulses(0, k);
            rdchk(`GEPC_COUNT_LO_OFS, place(0, k));
        end
        // level gating: edges outside the gate are ignored
        k = rnd();
        n = rnd();
        cfg(0, ctl(4'h6, 1'b1, 1'b1, `GEPC_GATE_HIGH, 1'b0));
        far.pulses(0, k);
        far.gate_to(0, 1'b1);
        far.pulses(0, n);
        far.gate_to(0, 1'b0);
        far.pulses(0, k);
        rdchk(`GEPC_COUNT_LO_OFS, place(0, n));
        // time lapse: counting starts at the gate edge
        cfg(0, ctl(4'h7, 1'b1, 1'b0, `GEPC_GATE_RISE, 1'b0));
        far.pulses(0, k);
        far.gate_to(0, 1'b1);
        far.pulses(0, n);
        rdchk(`GEPC_COUNT_LO_OFS, place(0, n));
        far.gate_to(0, 1'b0);
        // chained stage ignores its own source pin
        cfg01 = {ctl(`GEPC_TB_CHAIN, 1'b1, 1'b1, `GEPC_GATE_NONE, 1'b0),
            ctl(4'h6, 1'b1, 1'b1, `GEPC_GATE_NONE, 1'b0)};
        wr(`GEPC_CTRL_OFS, cfg01);
        far.pulses(1, k);
        far.pulses(0, n);
        rdchk(`GEPC_COUNT_LO_OFS, place(0, n));
        rdchk(`GEPC_COUNT_HI_OFS, 32'h0000_0000);
        // period on rising (stage 0) and falling (stage 2) gate edges
        for (int m = 0; m < 2; m++) begin
            s = m * 2;
            k = rnd();
            n = rnd();
            far.gate_to(s, m[0]);
            cfg(s, ctl(4'h8, 1'b1, 1'b1, 3'(`GEPC_GATE_RISE + m), 1'b1));
            far.pulses(s, 2);
            gate_edge(s, m[0]);
            far.pulses(s, k);
            gate_edge(s, m[0]);
            far.pulses(s, n);
            rdchk(hold_ofs(s), place(s, k));
            gate_edge(s, m[0]);
            rdchk(hold_ofs(s), place(s, n));
            far.gate_to(s, 1'b0);
        end
        // pulse width, high level on stage 1 and low level on stage 2
        for (int m = 0; m < 2; m++) begin
            s = m + 1;
            k = rnd();
            n = rnd();
            far.gate_to(s, m[0]);
            cfg(s, ctl(4'h9, 1'b1, 1'b1, 3'(`GEPC_GATE_HIGH + m), 1'b1));
            far.pulses(s, k);
            far.gate_to(s, ~m[0]);
            far.pulses(s, n);
            far.gate_to(s, m[0]);
            far.pulses(s, k);
            rdchk(hold_ofs(s), place(s, n));
            rdchk(cnt_ofs(s), 32'h0000_0000);
        end
        // rewriting the control word clears the held result
        cfg(2, ctl(4'h9, 1'b1, 1'b1, `GEPC_GATE_LOW, 1'b1));
        rdchk(`GEPC_HOLD_HI_OFS, 32'h0000_0000);
        // positive polarity, no rollover seen: every output rests low
        chk({29'h0, ctr_out}, 32'h0000_0000);
        wrap_up();
    end
endmodule
